// ===== src/gpio_pin_bank.sv
// Purpose: configuration and data registers for a bank of gpio pins
// Assumes: pins and register port synchronous to clock
// Notes: reset_n is the standby power reset, main_reset covers main power and hard reset
`timescale 1ns/1ps
module gpio_pin_bank (
    // clock and resets
    input wire logic clock,
    input wire logic reset_n,
    input wire logic main_reset,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // port one to four pads
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe,
    input wire logic [7:0] p2_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe,
    input wire logic [7:0] p3_in,
    output logic [7:0] p3_out,
    output logic [7:0] p3_oe,
    input wire logic [3:0] p4_in,
    output logic [3:0] p4_out,
    output logic [3:0] p4_oe,
    // configurable pads: 5.6, 5.7, 6.0, 6.1
    input wire logic [3:0] cp_in,
    output logic [3:0] cp_out,
    output logic [3:0] cp_oe,
    // led sources
    input wire logic first_led_drive,
    input wire logic second_led_drive,
    // interrupt outputs
    output logic irq11_out,
    output logic irq15_out,
    output logic irq
);
    logic rst_n; // synchronised standby reset
    gpio_bank_pkg::reg_req_type req; // bundled request
    gpio_bank_pkg::pin_cfg_type cfg_q [4]; // configurable pin setup
    logic [7:0] p1_q, p2_q, p3_q, p4_q; // port data
    logic [7:0] d1_q, d2_q, d3_q, d4_q; // port directions, one is input
    logic [3:0] cp_q; // data for configurable pins
    logic [1:0] stat_q, mask_q; // sticky edge events and their mask
    logic [1:0] prev_q; // last level of 6.0 and 6.1
    logic irq11_q, irq15_q;
    logic [7:0] rdata_q;

    // reset release
    gpio_reset_sync u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .rst_n(rst_n)
    );

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // readback of one bit: inputs show the pin, outputs the stored bit
    function automatic logic [7:0] readback(input logic [7:0] dir, input logic [7:0] lvl,
                                            input logic [7:0] stored);
        readback = (dir & lvl) | (~dir & stored);
    endfunction

    // write decode
    wire wr_p1 = req.wr && req.addr == gpio_bank_pkg::OFS_P1_DATA;
    wire wr_p2 = req.wr && req.addr == gpio_bank_pkg::OFS_P2_DATA;
    wire wr_p3 = req.wr && req.addr == gpio_bank_pkg::OFS_P3_DATA;
    wire wr_p4 = req.wr && req.addr == gpio_bank_pkg::OFS_P4_DATA;
    wire wr_d1 = req.wr && req.addr == gpio_bank_pkg::OFS_P1_DIR;
    wire wr_d2 = req.wr && req.addr == gpio_bank_pkg::OFS_P2_DIR;
    wire wr_d3 = req.wr && req.addr == gpio_bank_pkg::OFS_P3_DIR;
    wire wr_d4 = req.wr && req.addr == gpio_bank_pkg::OFS_P4_DIR;
    wire wr_cp = req.wr && req.addr == gpio_bank_pkg::OFS_CPIN_DATA;
    wire wr_st = req.wr && req.addr == gpio_bank_pkg::OFS_IRQ_STAT;
    wire wr_mk = req.wr && req.addr == gpio_bank_pkg::OFS_IRQ_MASK;
    wire [3:0] wr_cfg = {req.wr && req.addr == gpio_bank_pkg::OFS_P61_CFG,
                         req.wr && req.addr == gpio_bank_pkg::OFS_P60_CFG,
                         req.wr && req.addr == gpio_bank_pkg::OFS_P57_CFG,
                         req.wr && req.addr == gpio_bank_pkg::OFS_P56_CFG};

    // flattened plain ports; the reserved port two bit is forced input
    localparam logic [7:0] P2_HOLE = ~gpio_bank_pkg::P2_WMASK;
    wire [gpio_bank_pkg::GP_PINS-1:0] gp_dir = {d4_q[3:0], d3_q, d2_q | P2_HOLE, d1_q};
    wire [gpio_bank_pkg::GP_PINS-1:0] gp_data = {p4_q[3:0], p3_q, p2_q, p1_q};
    wire [gpio_bank_pkg::GP_PINS-1:0] gp_in = {p4_in, p3_in, p2_in, p1_in};
    logic [gpio_bank_pkg::GP_PINS-1:0] gp_out, gp_oe, gp_lvl;

    // plain port pins are push-pull with no inversion
    for (genvar i = 0; i < gpio_bank_pkg::GP_PINS; i++) begin : g_plain
        gpio_pin_cell u_cell (
            .is_input(gp_dir[i]),
            .invert(1'b0),
            .open_drain(1'b0),
            .out_value(gp_data[i]),
            .pin_in(gp_in[i]),
            .pin_out(gp_out[i]),
            .pin_oe(gp_oe[i]),
            .level(gp_lvl[i])
        );
    end

    assign p1_out = gp_out[7:0];
    assign p1_oe = gp_oe[7:0];
    assign p2_out = gp_out[15:8] & gpio_bank_pkg::P2_WMASK;
    assign p2_oe = gp_oe[15:8];
    assign p3_out = gp_out[23:16];
    assign p3_oe = gp_oe[23:16];
    assign p4_out = gp_out[27:24];
    assign p4_oe = gp_oe[27:24];

    // configurable pins: alternate irq inputs force the pad to input
    wire [3:0] cp_alt = {cfg_q[3].func == gpio_bank_pkg::FUNC_ALT,
                         cfg_q[2].func == gpio_bank_pkg::FUNC_ALT,
                         cfg_q[1].func == gpio_bank_pkg::FUNC_ALT,
                         cfg_q[0].func == gpio_bank_pkg::FUNC_ALT};
    // led select exists only on 6.0 and 6.1; on 5.x code 01 acts as gpio
    wire first_led_drive_sel = cfg_q[gpio_bank_pkg::CP_60].func == gpio_bank_pkg::FUNC_LED;
    wire second_led_drive_sel = cfg_q[gpio_bank_pkg::CP_61].func == gpio_bank_pkg::FUNC_LED;
    wire [3:0] cp_val = {second_led_drive_sel ? second_led_drive : cp_q[3],
                         first_led_drive_sel ? first_led_drive : cp_q[2], cp_q[1], cp_q[0]};
    logic [3:0] cp_lvl;
    logic [3:0] cp_dir;

    for (genvar i = 0; i < 4; i++) begin : g_conf
        assign cp_dir[i] = cfg_q[i].is_input | cp_alt[i];
        gpio_pin_cell u_cell (
            .is_input(cp_dir[i]),
            .invert(cfg_q[i].invert),
            .open_drain(cfg_q[i].open_drain),
            .out_value(cp_val[i]),
            .pin_in(cp_in[i]),
            .pin_out(cp_out[i]),
            .pin_oe(cp_oe[i]),
            .level(cp_lvl[i])
        );

        // configuration byte, reserved bits stay zero
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                cfg_q[i] <= gpio_bank_pkg::CFG_RESET;
            end else if (wr_cfg[i]) begin
                cfg_q[i] <= req.wdata & gpio_bank_pkg::CFG_WMASK;
            end
        end
    end

    // either-edge detection on the polarity adjusted level
    wire edge4 = cp_alt[gpio_bank_pkg::CP_60] && (cp_lvl[2] != prev_q[0]);
    wire edge5 = cp_alt[gpio_bank_pkg::CP_61] && (cp_lvl[3] != prev_q[1]);
    // a new event beats a clear in the same cycle
    wire [1:0] st_clr = wr_st ? req.wdata[1:0] : 2'b00;
    wire [1:0] stat_d = (stat_q & ~st_clr) | {edge5, edge4};

    // port three bit three also drops on main power or hard reset
    wire [7:0] p3_wr = wr_p3 ? req.wdata : p3_q;
    wire [7:0] p3_d = main_reset ? p3_wr & ~(8'h01 << gpio_bank_pkg::P3_MAIN_BIT) : p3_wr;

    // port data registers, all clear on standby reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            p1_q <= gpio_bank_pkg::DATA_RESET;
            p2_q <= gpio_bank_pkg::DATA_RESET;
            p3_q <= gpio_bank_pkg::DATA_RESET;
            p4_q <= gpio_bank_pkg::DATA_RESET;
        end else begin
            if (wr_p1) p1_q <= req.wdata;
            if (wr_p2) p2_q <= req.wdata & gpio_bank_pkg::P2_WMASK;
            p3_q <= p3_d;
            if (wr_p4) p4_q <= req.wdata & gpio_bank_pkg::P4_WMASK;
        end
    end

    // direction registers, every pin starts as an input so nothing fights the board
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            d1_q <= gpio_bank_pkg::DIR_RESET;
            d2_q <= gpio_bank_pkg::DIR_RESET;
            d3_q <= gpio_bank_pkg::DIR_RESET;
            d4_q <= gpio_bank_pkg::DIR_RESET;
        end else begin
            if (wr_d1) d1_q <= req.wdata;
            if (wr_d2) d2_q <= req.wdata;
            if (wr_d3) d3_q <= req.wdata;
            if (wr_d4) d4_q <= req.wdata;
        end
    end

    // configurable pin data, interrupt status and mask
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cp_q <= gpio_bank_pkg::CPIN_RESET;
            stat_q <= gpio_bank_pkg::STAT_RESET;
            mask_q <= gpio_bank_pkg::STAT_RESET;
            prev_q <= gpio_bank_pkg::STAT_RESET;
        end else begin
            if (wr_cp) cp_q <= req.wdata[3:0];
            if (wr_mk) mask_q <= req.wdata[1:0];
            stat_q <= stat_d;
            prev_q <= cp_lvl[3:2];
        end
    end

    // irq routing is registered so the lines never glitch
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq11_q <= 1'b0;
            irq15_q <= 1'b0;
        end else begin
            irq11_q <= cp_alt[gpio_bank_pkg::CP_56] && cp_lvl[0];
            irq15_q <= cp_alt[gpio_bank_pkg::CP_57] && cp_lvl[1];
        end
    end

    assign irq11_out = irq11_q;
    assign irq15_out = irq15_q;
    assign irq = |(stat_q & mask_q);

    // readback values
    wire [7:0] rb_p1 = readback(d1_q, p1_in, p1_q);
    wire [7:0] rb_p2 = readback(d2_q, p2_in, p2_q) & gpio_bank_pkg::P2_WMASK;
    wire [7:0] rb_p3 = readback(d3_q, p3_in, p3_q);
    wire [7:0] rb_p4 = readback(d4_q, {4'h0, p4_in}, p4_q) & gpio_bank_pkg::P4_WMASK;
    wire [7:0] rb_cp = readback({4'h0, cp_dir}, {4'h0, cp_lvl}, {4'h0, cp_q});
    wire [7:0] rd_mux =
        req.addr == gpio_bank_pkg::OFS_P56_CFG ? cfg_q[0] :
        req.addr == gpio_bank_pkg::OFS_P57_CFG ? cfg_q[1] :
        req.addr == gpio_bank_pkg::OFS_P60_CFG ? cfg_q[2] :
        req.addr == gpio_bank_pkg::OFS_P61_CFG ? cfg_q[3] :
        req.addr == gpio_bank_pkg::OFS_P1_DATA ? rb_p1 :
        req.addr == gpio_bank_pkg::OFS_P2_DATA ? rb_p2 :
        req.addr == gpio_bank_pkg::OFS_P3_DATA ? rb_p3 :
        req.addr == gpio_bank_pkg::OFS_P4_DATA ? rb_p4 :
        req.addr == gpio_bank_pkg::OFS_P1_DIR ? d1_q :
        req.addr == gpio_bank_pkg::OFS_P2_DIR ? d2_q :
        req.addr == gpio_bank_pkg::OFS_P3_DIR ? d3_q :
        req.addr == gpio_bank_pkg::OFS_P4_DIR ? d4_q :
        req.addr == gpio_bank_pkg::OFS_CPIN_DATA ? rb_cp :
        req.addr == gpio_bank_pkg::OFS_IRQ_STAT ? {6'h00, stat_q} :
        req.addr == gpio_bank_pkg::OFS_IRQ_MASK ? {6'h00, mask_q} :
        gpio_bank_pkg::ZERO_BYTE;

    // read data stands for exactly the cycle after the strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= gpio_bank_pkg::ZERO_BYTE;
        end else begin
            rdata_q <= req.rd ? rd_mux : gpio_bank_pkg::ZERO_BYTE;
        end
    end

    assign reg_rdata = rdata_q;

    // checks; everything here lives in the one clock domain of the bank
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // an input pin must leave its pad to the board
    a_input_no_drive: assert property (cfg_q[0].is_input |-> !cp_oe[0])
        else $error("input pin 5.6 is driven");
    // function 10 turns the pad around even while bit 0 says output
    a_alt_forces_input: assert property (cp_alt[2] |-> !cp_oe[2])
        else $error("interrupt input pin 6.0 is driven");
    // push-pull output shows the data bit through the polarity
    a_invert_output: assert property (
        !cp_dir[0] && !cfg_q[0].open_drain |-> cp_out[0] == (cp_q[0] ^ cfg_q[0].invert))
        else $error("pin 5.6 output polarity wrong");
    // open drain may pull low only, a one leaves the pad to the pull-up
    a_open_drain_low: assert property (cfg_q[0].open_drain && !cp_dir[0]
        |-> !cp_out[0] && (cp_oe[0] == (cp_q[0] == cfg_q[0].invert)))
        else $error("open drain pin 5.6 drives high");
    // routed irq lines follow the adjusted pin one edge late
    a_irq11_route: assert property (
        cp_alt[0] |=> irq11_out == $past(cp_in[0] ^ cfg_q[0].invert))
        else $error("irq11 does not follow pin 5.6");
    a_irq15_route: assert property (
        cp_alt[1] |=> irq15_out == $past(cp_in[1] ^ cfg_q[1].invert))
        else $error("irq15 does not follow pin 5.7");
    // led function replaces the data bit but keeps polarity
    a_first_led_drive_drive: assert property (
        first_led_drive_sel && !cp_dir[2] && !cfg_q[2].open_drain
        |-> cp_out[2] == (first_led_drive ^ cfg_q[2].invert))
        else $error("pin 6.0 does not drive led one");
    a_second_led_drive_drive: assert property (
        second_led_drive_sel && !cp_dir[3] && !cfg_q[3].open_drain
        |-> cp_out[3] == (second_led_drive ^ cfg_q[3].invert))
        else $error("pin 6.1 does not drive led two");
    // either edge of the adjusted level is caught at the next edge
    a_edge4_sticky: assert property (cp_alt[2] && $changed(cp_lvl[2]) |=> stat_q[0])
        else $error("edge on pin 6.0 not recorded");
    // a recorded event stays until software writes a one to it
    a_edge5_sticky: assert property (
        cp_alt[3] && $changed(cp_lvl[3]) ##1 !(wr_st && req.wdata[gpio_bank_pkg::STAT_SRC5])
        |-> stat_q[1] [*2])
        else $error("edge on pin 6.1 not kept");
    // a clear with no new event in the same cycle really drops the bit
    a_status_clear: assert property (
        wr_st && req.wdata[gpio_bank_pkg::STAT_SRC4] && !edge4 |=> !stat_q[0])
        else $error("source four status not cleared");
    // read data shows the selected register in the cycle after the strobe
    a_port1_read: assert property (req.rd && req.addr == gpio_bank_pkg::OFS_P1_DATA
        |=> reg_rdata == $past(rb_p1))
        else $error("port one readback wrong");
    // without a strobe the read data returns to zero
    a_rdata_idle: assert property (!req.rd |=> reg_rdata == gpio_bank_pkg::ZERO_BYTE)
        else $error("read data stands outside its cycle");
    // reserved and main-reset bits of the data ports
    a_port2_hole: assert property (
        !p2_oe[gpio_bank_pkg::P2_HOLE_BIT] && !p2_q[gpio_bank_pkg::P2_HOLE_BIT])
        else $error("port two bit three has a pin");
    a_port3_clear: assert property (main_reset |=> !p3_q[gpio_bank_pkg::P3_MAIN_BIT])
        else $error("port three bit three not cleared");
    a_port4_upper: assert property (req.rd && req.addr == gpio_bank_pkg::OFS_P4_DATA
        |=> reg_rdata[7:4] == 4'h0)
        else $error("port four reserved bits not zero");
    // plain port pins are push-pull outputs of their data bit
    a_push_pull_drive: assert property (
        !gp_dir[0] |-> p1_oe[0] && p1_out[0] == p1_q[0])
        else $error("port one output not driven");

    // main scenarios the bench is expected to reach
    c_edge_irq: cover property (cp_alt[2] && mask_q[0] ##1 stat_q[0] ##1 irq);
    c_led_two: cover property (second_led_drive_sel && !cp_dir[3] && cp_oe[3]);
    c_irq15_high: cover property (irq15_out);
    c_port3_main: cover property (p3_q[3] ##1 main_reset ##1 !p3_q[3]);
endmodule

// ===== include/gpio_bank_pkg.sv
// Purpose: shared constants and types for the gpio pin bank
// Assumes: 8-bit register port, byte offsets as printed
// Notes: offsets at 0x60 and above belong to this block's own extra registers
package gpio_bank_pkg;

    // register offsets
    localparam logic [7:0] OFS_P56_CFG = 8'h45;
    localparam logic [7:0] OFS_P57_CFG = 8'h46;
    localparam logic [7:0] OFS_P60_CFG = 8'h47;
    localparam logic [7:0] OFS_P61_CFG = 8'h48;
    localparam logic [7:0] OFS_P1_DATA = 8'h4b;
    localparam logic [7:0] OFS_P2_DATA = 8'h4c;
    localparam logic [7:0] OFS_P3_DATA = 8'h4d;
    localparam logic [7:0] OFS_P4_DATA = 8'h4e;
    localparam logic [7:0] OFS_P1_DIR = 8'h60;
    localparam logic [7:0] OFS_P2_DIR = 8'h61;
    localparam logic [7:0] OFS_P3_DIR = 8'h62;
    localparam logic [7:0] OFS_P4_DIR = 8'h63;
    localparam logic [7:0] OFS_CPIN_DATA = 8'h64;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h65;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h66;

    // reset values and writable masks
    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam logic [7:0] CFG_WMASK = 8'h8f;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] P2_WMASK = 8'hf7;
    localparam logic [7:0] P4_WMASK = 8'h0f;
    localparam logic [3:0] CPIN_RESET = 4'h0;
    localparam logic [1:0] STAT_RESET = 2'h0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // field positions
    localparam int P2_HOLE_BIT = 3;
    localparam int P3_MAIN_BIT = 3;
    localparam int CP_56 = 0;
    localparam int CP_57 = 1;
    localparam int CP_60 = 2;
    localparam int CP_61 = 3;
    localparam int STAT_SRC4 = 0;
    localparam int STAT_SRC5 = 1;
    localparam int GP_PINS = 28;

    // function select codes
    localparam logic [1:0] FUNC_GPIO = 2'h0;
    localparam logic [1:0] FUNC_LED = 2'h1;
    localparam logic [1:0] FUNC_ALT = 2'h2;

    // configuration byte layout, msb first
    typedef struct packed {
        logic open_drain;
        logic [2:0] rsvd;
        logic [1:0] func;
        logic invert;
        logic is_input;
    } pin_cfg_type;

    // one register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

endpackage

// ===== src/gpio_reset_sync.sv
// Purpose: release an async active-low reset through two flops
// Assumes: single clock domain
// Notes: assertion is immediate, release takes two edges
`timescale 1ns/1ps
module gpio_reset_sync (
    // clock and raw reset
    input wire logic clock,
    input wire logic reset_n,
    // synchronised reset
    output logic rst_n
);
    logic stage_q; // first stage, read only by the second

    // shift in a one after release so release is glitch free
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            stage_q <= 1'b1;
            rst_n <= stage_q;
        end
    end
endmodule

// ===== src/gpio_pin_cell.sv
// Purpose: one pin's direction, polarity and driver type
// Assumes: pin_in is already synchronous to the clock
// Notes: purely combinational, the caller registers what it needs
`timescale 1ns/1ps
module gpio_pin_cell (
    // configuration
    input wire logic is_input,
    input wire logic invert,
    input wire logic open_drain,
    // value to present before polarity
    input wire logic out_value,
    // pad
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // polarity adjusted pin level
    output logic level
);
    logic drive_value; // value after polarity

    assign drive_value = out_value ^ invert;
    // open drain never drives a one, it lets the board pull up
    assign pin_out = open_drain ? 1'b0 : drive_value;
    assign pin_oe = !is_input && (!open_drain || !drive_value);
    assign level = pin_in ^ invert;
endmodule

// ===== dv/gpio_board_model.sv
// Purpose: board side of the gpio pads, with a pull-up on every pad
// Assumes: one pad per bit, the bench concatenates all pad groups
// Notes: a released pad with no board driver floats high, never keeps the old value
`timescale 1ns/1ps
module gpio_board_model #(
    parameter int W = 32
) (
    // pad outputs of the bank
    input wire logic [W-1:0] pad_out,
    input wire logic [W-1:0] pad_oe,
    // board drivers, commanded by the bench
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    // resolved pad level fed back to the bank
    output logic [W-1:0] pad_level
);
    // bank drive wins, then a board driver, else the pull-up lifts the pad
    assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
        | (~pad_oe & ~ext_en);
endmodule

// ===== dv/tb_gpio_pin_bank.sv
// Purpose: self-checking bench for the gpio pin bank
// Assumes: register port with read data one cycle after the strobe
// Notes: pads resolve through the board model; led and reset inputs toggled by tests
`timescale 1ns/1ps
module tb_gpio_pin_bank;
    // clock, resets and register port
    logic clock, reset_n, main_reset, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    // pads, led sources and interrupts
    logic [7:0] p1_out, p1_oe, p2_out, p2_oe, p3_out, p3_oe;
    logic [3:0] p4_out, p4_oe, cp_out, cp_oe;
    logic first_led_drive, second_led_drive, irq11_out, irq15_out, irq;
    logic [31:0] ext_en, ext_val, pads;
    // bookkeeping
    int miscompares, n_compared;
    logic [7:0] rsts [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] adrs [8] = '{8'h45, 8'h46, 8'h47, 8'h48, 8'h4b, 8'h4c, 8'h4d, 8'h4e};

    gpio_pin_bank u_gpio_pin_bank (.clock(clock), .reset_n(reset_n),
        .main_reset(main_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .p1_in(pads[7:0]), .p1_out(p1_out), .p1_oe(p1_oe),
        .p2_in(pads[15:8]), .p2_out(p2_out), .p2_oe(p2_oe),
        .p3_in(pads[23:16]), .p3_out(p3_out), .p3_oe(p3_oe),
        .p4_in(pads[27:24]), .p4_out(p4_out), .p4_oe(p4_oe),
        .cp_in(pads[31:28]), .cp_out(cp_out), .cp_oe(cp_oe),
        .first_led_drive(first_led_drive), .second_led_drive(second_led_drive),
        .irq11_out(irq11_out), .irq15_out(irq15_out), .irq(irq));

    gpio_board_model u_gpio_board_model (.pad_out({cp_out, p4_out, p3_out, p2_out, p1_out}),
        .pad_oe({cp_oe, p4_oe, p3_oe, p2_oe, p1_oe}), .ext_en(ext_en), .ext_val(ext_val),
        .pad_level(pads));

    // free running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // byte compare, counted
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one cycle write strobe
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // one cycle read strobe, data looked at in the following cycle only
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // let one edge land, then look at settled outputs
    task step;
        @(posedge clock);
        #1;
    endtask

    task end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, miscompares);
    endtask

    task print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // a hang is cut short here
    initial begin
        repeat (100000) @(posedge clock);
        miscompares++;
        $display("Error at %0t: run took too long", $time);
        print_verdict;
    end

    initial begin
        {reset_n, main_reset, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {first_led_drive, second_led_drive, ext_en, ext_val} = '0;
        // plain port pads held low by the board so reset reads see zero
        ext_en = 32'h0fffffff;
        miscompares = 0;
        n_compared = 0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        // reset values, then reserved config bits read back as zero
        foreach (adrs[i]) rd(adrs[i], rsts[i]);
        for (int i = 0; i < 4; i++) begin
            wr(adrs[i], 8'hff);
            rd(adrs[i], 8'h8f);
            wr(adrs[i], 8'h01);
        end
        wr(8'h49, 8'hff);
        rd(8'h49, 8'h00);
        end_test("reset_and_map");
        // port one as input through the board, then as output
        ext_en[7:0] <= 8'hff;
        ext_val[7:0] <= 8'h3c;
        rd(8'h4b, 8'h3c);
        ext_en[7:0] <= 8'h00;
        wr(8'h60, 8'h00);
        wr(8'h4b, 8'ha5);
        step;
        chk(p1_out, 8'ha5);
        chk(p1_oe, 8'hff);
        rd(8'h4b, 8'ha5);
        // port two hole, port four upper bits, port three main reset bit
        wr(8'h61, 8'h00);
        wr(8'h4c, 8'hff);
        rd(8'h4c, 8'hf7);
        chk(p2_oe, 8'hf7);
        chk(p2_out, 8'hf7);
        wr(8'h63, 8'h00);
        wr(8'h4e, 8'hff);
        rd(8'h4e, 8'h0f);
        chk({4'h0, p4_oe}, 8'h0f);
        chk({4'h0, p4_out}, 8'h0f);
        wr(8'h62, 8'h00);
        wr(8'h4d, 8'hff);
        @(posedge clock);
        main_reset <= 1'b1;
        @(posedge clock);
        main_reset <= 1'b0;
        rd(8'h4d, 8'hf7);
        chk(p3_out, 8'hf7);
        chk(p3_oe, 8'hff);
        end_test("port_data");
        // push-pull inverted, then open drain on pin 5.6
        wr(8'h45, 8'h02);
        wr(8'h64, 8'h01);
        step;
        chk({6'h0, cp_oe[0], cp_out[0]}, 8'h02);
        wr(8'h45, 8'h80);
        step;
        chk({7'h0, cp_oe[0]}, 8'h00);
        wr(8'h64, 8'h00);
        step;
        chk({6'h0, cp_oe[0], cp_out[0]}, 8'h02);
        end_test("drivers");
        // irq routing of 5.6 and inverted 5.7, output bit ignored under function 10
        ext_en[29:28] <= 2'b11;
        ext_val[29:28] <= 2'b01;
        wr(8'h45, 8'h08);
        wr(8'h46, 8'h0a);
        step;
        step;
        chk({5'h0, cp_oe[0], irq15_out, irq11_out}, 8'h03);
        ext_val[29:28] <= 2'b10;
        step;
        step;
        chk({6'h0, irq15_out, irq11_out}, 8'h00);
        end_test("irq_route");
        // a rising edge on 6.0 raises source four, masked 6.1 stays quiet
        ext_en[31:30] <= 2'b11;
        ext_val[31:30] <= 2'b00;
        wr(8'h47, 8'h09);
        wr(8'h48, 8'h09);
        wr(8'h66, 8'h01);
        wr(8'h65, 8'h03);
        rd(8'h65, 8'h00);
        @(posedge clock);
        ext_val[31:30] <= 2'b01;
        step;
        step;
        chk({7'h0, irq}, 8'h01);
        wr(8'h65, 8'h01);
        step;
        chk({7'h0, irq}, 8'h00);
        ext_val[31:30] <= 2'b11;
        step;
        step;
        chk({7'h0, irq}, 8'h00);
        rd(8'h65, 8'h02);
        wr(8'h66, 8'h02);
        step;
        chk({7'h0, irq}, 8'h01);
        wr(8'h65, 8'h03);
        rd(8'h65, 8'h00);
        end_test("edge_irq");
        // led drive on 6.0 and 6.1
        ext_en[31:30] <= 2'b00;
        wr(8'h47, 8'h04);
        wr(8'h48, 8'h04);
        first_led_drive <= 1'b1;
        step;
        chk({4'h0, cp_oe[3:2], cp_out[3:2]}, 8'h0d);
        first_led_drive <= 1'b0;
        second_led_drive <= 1'b1;
        step;
        chk({4'h0, cp_oe[3:2], cp_out[3:2]}, 8'h0e);
        end_test("led");
        print_verdict;
    end
endmodule
